// ---- logic/timer_defs.svh ----
// Register addresses, field positions, encodings and reset values of the timer block
`ifndef TIMER_DEFS_SVH
`define TIMER_DEFS_SVH

// APB address width
`define APB_ADDR_W      20

// Port registers: printed offsets are register indices, byte address is four times the index
`define PORT2_DIR_IDX   16'hff22
`define PORT2_ANA_IDX   16'hff84

// Timer registers, byte addresses
`define ADDR_COUNTER    20'h0_0000
`define ADDR_CAPCMP_A   20'h0_0004
`define ADDR_CAPCMP_B   20'h0_0008
`define ADDR_MODE_CTRL  20'h0_000c
`define ADDR_CC_CTRL    20'h0_0010
`define ADDR_PRESCALER  20'h0_0014
`define ADDR_STATUS     20'h0_0018

// Reset values, read-back high nibbles and counter limits
`define PORT2_DIR_RST   4'hf
`define PORT2_ANA_RST   4'h0
`define PORT2_DIR_HI    4'hf
`define PORT2_ANA_HI    4'h0
`define PRM_RST         8'h00
`define COUNT_ZERO      16'h0000
`define COUNT_MAX       16'hffff

// Prescaler mode register fields
`define PRM_CLK         1:0
`define PRM_EDGE_A      5:4
`define PRM_EDGE_B      7:6
`define PRM_WMASK       8'hf3

// Count clock selections
`define CLK_FULL        2'b00
`define CLK_DIV4        2'b01
`define CLK_DIV256      2'b10
`define CLK_EXT_A       2'b11

// Prescaler terminal values
`define DIV4_LAST       2'h3
`define DIV256_LAST     8'hff

// Edge select encodings (2'b10 is prohibited and detects nothing)
`define EDGE_FALL       2'b00
`define EDGE_RISE       2'b01
`define EDGE_BOTH       2'b11

// Timer mode control encodings
`define MODE_STOP       2'b00
`define MODE_FREE       2'b01
`define MODE_CLEAR      2'b10

// Capture/compare control: register A captures on input B edges
`define CC_CAPT_A_BIT   0
// Status register: sticky overflow flag, write 1 to clear
`define STAT_OVF_BIT    0

`endif

// ---- logic/timer_pkg.sv ----
// Types shared by the timer block and its input filter
`default_nettype none
package timer_pkg;

    // State of one input edge filter
    typedef struct packed {
        logic armed;    // Filter has one sample since start
        logic sample;   // Last sampled pin level
        logic level;    // Level confirmed by two equal samples
        logic edge_p;   // Valid edge pulse
    } filter_state_t;

    // Whole state of the timer core
    typedef struct packed {
        logic [7:0]  pre;       // Prescaler
        logic [15:0] cnt;       // Up counter
        logic [15:0] cra;       // Capture/compare A
        logic [15:0] crb;       // Capture/compare B
        logic [7:0]  prm;       // Prescaler mode
        logic [1:0]  tmc;       // Timer mode
        logic        crc;       // Capture A enable
        logic        ovf;       // Sticky overflow flag
        logic [3:0]  dir;       // Pin direction bits
        logic [3:0]  ana;       // Pin analog bits
        logic [31:0] rdata;     // APB read data
        logic        match_p;   // Match A request pulse
        logic        capb_p;    // Capture B request pulse
    } timer_state_t;

endpackage
`default_nettype wire

// ---- logic/edge_filter.sv ----
// Two-sample noise filter and valid-edge detector for one timer input pin
`timescale 1ns/1ps
`default_nettype none
`include "timer_defs.svh"
module edge_filter (
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Control
    input  wire logic       arm,
    input  wire logic       sample,
    input  wire logic [1:0] edge_sel,
    // Pin and result
    input  wire logic       din,
    output logic            edge_pulse
);

    timer_pkg::filter_state_t q;   // Registered state
    timer_pkg::filter_state_t d;   // Next state

    // True when a change to level new_lvl is a valid edge for sel
    function automatic logic edge_ok(input logic [1:0] sel, input logic new_lvl);
        edge_ok = 1'b0;
        unique case (sel)
            `EDGE_FALL: edge_ok = !new_lvl;
            `EDGE_RISE: edge_ok = new_lvl;
            `EDGE_BOTH: edge_ok = 1'b1;
            default:    edge_ok = 1'b0;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Level is accepted only after two equal samples, so short pulses vanish.
    // Level starts at 0 on arming, so a high pin at start gives a rising edge.
    always_comb begin
        d        = q;
        d.edge_p = 1'b0;
        if (!arm) begin
            d = '0;
        end else if (sample) begin
            d.armed  = 1'b1;
            d.sample = din;
            // Second equal sample confirms a new level
            if (q.armed && (q.sample == din) && (q.level != din)) begin
                d.level  = din;
                d.edge_p = edge_ok(edge_sel, din);
            end
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign edge_pulse = q.edge_p;

endmodule // edge_filter
`default_nettype wire

// ---- logic/timer_event_counter_capture.sv ----
// 16-bit timer/event counter with capture, port mode registers and APB slave
//
// Behaviour
// - direction bit 0 drives pin, 1 input
// - analog bit 1 selects converter input
// - interval match clears counter, raises match request
// - prescaler bits 1:0 select count clock
// - interval is compare value plus one clocks
// - compare modes flag overflow only at FFFFH
// - lowered compare value lets counter run through
// - event mode counts each valid input A edge
// - event mode match clears counter, raises request
// - prescaler bits 5:4 select input A edge
// - event edges need two equal pclk samples
// - counting starts after first twice-seen edge
// - capture edges sampled twice at count clock
// - input A edge captures count into B
// - input B edge captures into A, match request
// - free-running wrap sets overflow flag anyway
// - edge code 00 fall, 01 rise, 11 both
// - count clock full, /4, /256 or edge A
`timescale 1ns/1ps
`default_nettype none
`include "timer_defs.svh"
module timer_event_counter_capture (
    // Clock and reset
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    // APB slave
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [`APB_ADDR_W-1:0] paddr,
    input  wire logic [31:0]            pwdata,
    output logic [31:0]                 prdata,
    output logic                        pready,
    output logic                        pslverr,
    // Timer input pins
    input  wire logic                   event_input_a,
    input  wire logic                   event_input_b,
    // Requests and flags
    output logic                        match_a_irq,
    output logic                        capture_b_irq,
    output logic                        overflow_flag,
    // Shared pin control
    output logic [3:0]                  pin_direction_bit,
    output logic [3:0]                  pin_analog_bit,
    output logic [3:0]                  pin_out_en
);

    timer_pkg::timer_state_t q;     // Registered state
    timer_pkg::timer_state_t d;     // Next state

    logic running;                  // Timer mode is not stop
    logic pre_tick;                 // Internal count clock enable
    logic tick;                     // Selected count clock enable
    logic ext_clk;                  // Count clock is input A edges
    logic edge_a;                   // Filtered valid edge on input A
    logic edge_b;                   // Filtered valid edge on input B
    logic sample_a;                 // Sampling strobe of input A filter
    logic wr_en;                    // APB write in access phase
    logic rd_setup;                 // APB read in setup phase
    logic mapped;                   // Address hits a register

    // Byte address of a port register from its printed index
    function automatic logic [`APB_ADDR_W-1:0] idx_addr(input logic [15:0] idx);
        idx_addr = {2'b00, idx, 2'b00};
    endfunction

    // True when addr decodes to one of the registers
    function automatic logic hit(input logic [`APB_ADDR_W-1:0] addr);
        hit = (addr == `ADDR_COUNTER) || (addr == `ADDR_CAPCMP_A) ||
              (addr == `ADDR_CAPCMP_B) || (addr == `ADDR_MODE_CTRL) ||
              (addr == `ADDR_CC_CTRL) || (addr == `ADDR_PRESCALER) ||
              (addr == `ADDR_STATUS) || (addr == idx_addr(`PORT2_DIR_IDX)) ||
              (addr == idx_addr(`PORT2_ANA_IDX));
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Count clock selection

    assign running = (q.tmc != `MODE_STOP);
    assign ext_clk = (q.prm[`PRM_CLK] == `CLK_EXT_A);

    // Internal divided clock enables off the prescaler, which only runs while the timer runs
    always_comb begin
        unique case (q.prm[`PRM_CLK])
            `CLK_FULL:   pre_tick = 1'b1;
            `CLK_DIV4:   pre_tick = (q.pre[1:0] == `DIV4_LAST);
            `CLK_DIV256: pre_tick = (q.pre == `DIV256_LAST);
            `CLK_EXT_A:  pre_tick = 1'b0;
        endcase
    end

    // In event mode input A edges are the count clock
    assign tick = ext_clk ? edge_a : pre_tick;

    // Input A is sampled at pclk when it is the clock, else at the count clock
    assign sample_a = ext_clk ? 1'b1 : pre_tick;

    ////////////////////////////////////////////////////////////////////////////
    // Input filters; both are held clear while the timer is stopped, so the
    // first count or capture needs a fresh twice-seen edge after start

    edge_filter u_filter_a (
        .pclk       (pclk),
        .presetn    (presetn),
        .arm        (running),
        .sample     (sample_a),
        .edge_sel   (q.prm[`PRM_EDGE_A]),
        .din        (event_input_a),
        .edge_pulse (edge_a)
    );

    edge_filter u_filter_b (
        .pclk       (pclk),
        .presetn    (presetn),
        .arm        (running),
        .sample     (pre_tick),
        .edge_sel   (q.prm[`PRM_EDGE_B]),
        .din        (event_input_b),
        .edge_pulse (edge_b)
    );

    ////////////////////////////////////////////////////////////////////////////
    // APB decode: always ready, read data captured in the setup cycle

    assign wr_en    = psel && penable && pwrite;
    assign rd_setup = psel && !penable && !pwrite;
    assign mapped   = hit(paddr);

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic: bus writes first, hardware events after so they win

    always_comb begin
        d         = q;
        d.match_p = 1'b0;
        d.capb_p  = 1'b0;

        // Prescaler runs only while the timer runs, so division starts aligned
        d.pre = running ? q.pre + 8'h01 : 8'h00;

        // Register writes
        if (wr_en) begin
            unique case (paddr)
                `ADDR_CAPCMP_A:  d.cra = pwdata[15:0];
                `ADDR_CAPCMP_B:  d.crb = pwdata[15:0];
                `ADDR_MODE_CTRL: d.tmc = pwdata[1:0];
                `ADDR_CC_CTRL:   d.crc = pwdata[`CC_CAPT_A_BIT];
                `ADDR_PRESCALER: d.prm = pwdata[7:0] & `PRM_WMASK;
                `ADDR_STATUS: begin
                    // Write 1 clears; a same-cycle overflow sets it again below
                    if (pwdata[`STAT_OVF_BIT]) begin
                        d.ovf = 1'b0;
                    end
                end
                default: begin
                    // Port registers and read-only counter
                    if (paddr == idx_addr(`PORT2_DIR_IDX)) begin
                        d.dir = pwdata[3:0];
                    end else if (paddr == idx_addr(`PORT2_ANA_IDX)) begin
                        d.ana = pwdata[3:0];
                    end
                end
            endcase
        end

        // Counter
        if (!running) begin
            d.cnt = `COUNT_ZERO;
        end else if (tick) begin
            if (q.tmc == `MODE_CLEAR) begin
                if (q.cnt == q.cra) begin
                    // Match clears and keeps counting: period is value plus one
                    d.cnt     = `COUNT_ZERO;
                    d.match_p = 1'b1;
                    if (q.cra == `COUNT_MAX) begin
                        d.ovf = 1'b1;
                    end
                end else begin
                    // A compare below the count is passed: wraps without a flag
                    d.cnt = q.cnt + 16'h0001;
                end
            end else begin
                // Free-running wrap
                d.cnt = q.cnt + 16'h0001;
                if (q.cnt == `COUNT_MAX) begin
                    d.ovf = 1'b1;
                end
            end
        end

        // Captures in free-running mode; input A is unusable as a trigger
        // while it is also the count clock
        if ((q.tmc == `MODE_FREE) && !ext_clk) begin
            if (edge_a) begin
                d.crb    = q.cnt;
                d.capb_p = 1'b1;
            end
            if (edge_b && q.crc) begin
                d.cra     = q.cnt;
                d.match_p = 1'b1;
            end
        end

        // Read data is latched in the setup cycle and shown in the access cycle
        if (rd_setup) begin
            unique case (paddr)
                `ADDR_COUNTER:   d.rdata = {16'h0000, q.cnt};
                `ADDR_CAPCMP_A:  d.rdata = {16'h0000, q.cra};
                `ADDR_CAPCMP_B:  d.rdata = {16'h0000, q.crb};
                `ADDR_MODE_CTRL: d.rdata = {30'h0000_0000, q.tmc};
                `ADDR_CC_CTRL:   d.rdata = {31'h0000_0000, q.crc};
                `ADDR_PRESCALER: d.rdata = {24'h00_0000, q.prm};
                `ADDR_STATUS:    d.rdata = {31'h0000_0000, q.ovf};
                default: begin
                    if (paddr == idx_addr(`PORT2_DIR_IDX)) begin
                        d.rdata = {24'h00_0000, `PORT2_DIR_HI, q.dir};
                    end else if (paddr == idx_addr(`PORT2_ANA_IDX)) begin
                        d.rdata = {24'h00_0000, `PORT2_ANA_HI, q.ana};
                    end else begin
                        d.rdata = 32'h0000_0000;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q     <= '0;
            q.prm <= `PRM_RST;
            q.dir <= `PORT2_DIR_RST;
            q.ana <= `PORT2_ANA_RST;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    // Zero-wait slave; unmapped addresses answer with an error
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata  = q.rdata;

    // One-cycle request pulses and the sticky flag
    assign match_a_irq   = q.match_p;
    assign capture_b_irq = q.capb_p;
    assign overflow_flag = q.ovf;

    // Pin control: 0 turns the output buffer on, analog bit selects converter
    assign pin_direction_bit = q.dir;
    assign pin_analog_bit    = q.ana;
    assign pin_out_en        = ~q.dir;

endmodule // timer_event_counter_capture
`default_nettype wire

// ---- testbench/timer_monitor.sv ----
// Port-level concurrent checks for the timer block
`timescale 1ns/1ps
`default_nettype none
`include "timer_defs.svh"
module timer_monitor (
    // Clock and reset
    input wire logic                   pclk,
    input wire logic                   presetn,
    // APB side
    input wire logic                   psel,
    input wire logic                   penable,
    input wire logic                   pwrite,
    input wire logic [`APB_ADDR_W-1:0] paddr,
    input wire logic [31:0]            pwdata,
    input wire logic [31:0]            prdata,
    input wire logic                   pready,
    input wire logic                   pslverr,
    // Pins, requests and flags
    input wire logic                   event_input_a,
    input wire logic                   event_input_b,
    input wire logic                   match_a_irq,
    input wire logic                   capture_b_irq,
    input wire logic                   overflow_flag,
    input wire logic [3:0]             pin_direction_bit,
    input wire logic [3:0]             pin_analog_bit,
    input wire logic [3:0]             pin_out_en
);
    ////////////////////////////////////////////////////////////
    // Port registers sit at four times their index
    localparam logic [19:0] DIR_ADDR = {2'b00, `PORT2_DIR_IDX, 2'b00};
    localparam logic [19:0] ANA_ADDR = {2'b00, `PORT2_ANA_IDX, 2'b00};
    logic wr_acc; // Write completing at this edge
    assign wr_acc = psel & penable & pwrite;

    // Single clock domain, so one clocking and one disable
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    ////////////////////////////////////////////////////////////
    property p_unmapped;
        psel && penable && paddr == 20'h0_0040 |-> pslverr && prdata == 32'h0000_0000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
    property p_slverr;
        pslverr |-> psel && penable;
    endproperty
    a_slverr: assert property (p_slverr) else $error("error response outside access");
    property p_oe;
        pin_out_en == ~pin_direction_bit;
    endproperty
    a_oe: assert property (p_oe) else $error("buffer enable disagrees with direction");
    property p_dir;
        wr_acc && paddr == DIR_ADDR |=> pin_direction_bit == $past(pwdata[3:0]);
    endproperty
    a_dir: assert property (p_dir) else $error("direction bits not written");
    property p_ana;
        wr_acc && paddr == ANA_ADDR |=> pin_analog_bit == $past(pwdata[3:0]);
    endproperty
    a_ana: assert property (p_ana) else $error("analog bits not written");
    property p_match;
        match_a_irq |=> !match_a_irq;
    endproperty
    a_match: assert property (p_match) else $error("match request longer than a cycle");
    property p_capb;
        capture_b_irq |=> !capture_b_irq;
    endproperty
    a_capb: assert property (p_capb) else $error("capture request longer than a cycle");
    // Sticky flag: only a write of one to status may drop it
    property p_ovf;
        $fell(overflow_flag) |-> $past(wr_acc && paddr == `ADDR_STATUS && pwdata[0]);
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow flag dropped by itself");
endmodule // timer_monitor
`default_nettype wire

// ---- testbench/pulse_source.sv ----
// Behavioural model of the two external pulse sources on the timer inputs
`timescale 1ns/1ps
`default_nettype none
module pulse_source (
    // Clock
    input  wire logic pclk,
    // Pins into the timer
    output var logic  pin_a,
    output var logic  pin_b
);
    ////////////////////////////////////////////////////////////
    // Idle low, so the first valid edge after start is a rise
    initial begin
        pin_a = 1'b0;
        pin_b = 1'b0;
    end

    // Set both levels; called just after a clock edge
    task automatic set(input logic a, input logic b);
        pin_a <= a;
        pin_b <= b;
    endtask

    // Train on pin A; each level holds w edges, at least two so the filter agrees
    task automatic train(input int n, input int w);
        repeat (n) begin
            pin_a <= 1'b1;
            repeat (w) @(posedge pclk);
            pin_a <= 1'b0;
            repeat (w) @(posedge pclk);
        end
    endtask

    // One-cycle spike, too short to be seen twice
    task automatic glitch();
        pin_a <= 1'b1;
        @(posedge pclk);
        pin_a <= 1'b0;
        @(posedge pclk);
    endtask
endmodule // pulse_source
`default_nettype wire

// ---- testbench/tb_top.sv ----
// Self-checking bench for the timer block
`timescale 1ns/1ps
`default_nettype none
`include "timer_defs.svh"
module tb_top;
    ////////////////////////////////////////////////////////////
    // APB master and reset
    logic        pclk    = 1'b0;
    logic        presetn = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [19:0] paddr   = 20'h0_0000;
    logic [31:0] pwdata  = 32'h0000_0000;
    // Design outputs and pins
    logic [31:0] prdata;
    logic        pready, pslverr, match_a_irq, capture_b_irq, overflow_flag;
    logic [3:0]  dir_bits, ana_bits, out_en, v;
    logic        ev_a, ev_b;
    // Bookkeeping
    int          err_total = 0;
    int          n_checks  = 0;
    int          cyc       = 0; // Free cycle count
    int          n_match   = 0; // Match pulses seen
    int          n_capb    = 0; // Capture pulses seen
    integer      seed      = 17;
    logic [31:0] rd;            // Last read data
    logic        er;            // Last error response
    logic [15:0] c1, c2;
    int          n, g, k, t0;
    localparam logic [19:0] DIR_ADDR = {2'b00, `PORT2_DIR_IDX, 2'b00};
    localparam logic [19:0] ANA_ADDR = {2'b00, `PORT2_ANA_IDX, 2'b00};

    always #50 pclk = ~pclk;

    // Pulses last one cycle, so they are counted at every edge
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (match_a_irq === 1'b1) n_match <= n_match + 1;
        if (capture_b_irq === 1'b1) n_capb <= n_capb + 1;
    end

    timer_event_counter_capture u_timer_event_counter_capture (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .event_input_a(ev_a), .event_input_b(ev_b), .match_a_irq(match_a_irq),
        .capture_b_irq(capture_b_irq), .overflow_flag(overflow_flag),
        .pin_direction_bit(dir_bits), .pin_analog_bit(ana_bits), .pin_out_en(out_en));
    pulse_source u_pulse_source (.pclk(pclk), .pin_a(ev_a), .pin_b(ev_b));

    ////////////////////////////////////////////////////////////
    // Expected count clock divide and edge count
    function automatic int div_of(input logic [1:0] s);
        return (s == 2'b00) ? 1 : (s == 2'b01) ? 4 : 256;
    endfunction
    function automatic int edges_of(input logic [1:0] c, input int p);
        return (c == `EDGE_BOTH) ? 2 * p : (c == 2'b10) ? 0 : p;
    endfunction

    // Compare and count
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // One transfer, held until pready is seen at an edge
    task automatic apb(input logic w, input logic [19:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input string nm, input logic [19:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(nm, rd, exp);
    endtask

    // Edges until the next match pulse
    task automatic gap(output int cnt);
        cnt = 0;
        do begin
            @(posedge pclk);
            cnt++;
        end while (match_a_irq !== 1'b1 && cnt < 9000);
    endtask

    task automatic wait_to(input int t);
        while (cyc < t) @(posedge pclk);
    endtask

    task automatic end_sim();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values, unmapped place, port registers
        rdchk("dir reset", DIR_ADDR, 32'h0000_00ff);
        rdchk("ana reset", ANA_ADDR, 32'h0000_0000);
        rdchk("unmapped", 20'h0_0040, 32'h0000_0000);
        chk("unmapped err", {31'h0, er}, 32'h0000_0001);
        v = 4'($random(seed));
        apb(1'b1, DIR_ADDR, {28'h0, v});
        rdchk("dir rw", DIR_ADDR, {24'h0, 4'hf, v});
        chk("out enable", {28'h0, out_en}, {28'h0, ~v});
        apb(1'b1, ANA_ADDR, {28'h0, ~v});
        // The write lands at the access edge, so look one edge later
        @(posedge pclk);
        chk("ana pins", {28'h0, ana_bits}, {28'h0, ~v});
        apb(1'b1, `ADDR_PRESCALER, 32'h0000_00ff);
        rdchk("prm mask", `ADDR_PRESCALER, 32'h0000_00f3);
        // Interval at each internal count clock, set up in order
        for (int s = 0; s < 3; s++) begin
            n = 3 + ($random(seed) & 7);
            apb(1'b1, `ADDR_MODE_CTRL, 32'h0000_0000);
            apb(1'b1, `ADDR_CC_CTRL, 32'h0000_0000);
            apb(1'b1, `ADDR_CAPCMP_A, 32'(n));
            apb(1'b1, `ADDR_PRESCALER, 32'(s));
            apb(1'b1, `ADDR_MODE_CTRL, {30'h0, `MODE_CLEAR});
            gap(g);
            gap(g);
            chk("interval", 32'(g), 32'((n + 1) * div_of(2'(s))));
        end
        chk("no ovf", {31'h0, overflow_flag}, 32'h0000_0000);
        // Event counting under every edge code, with a spike to reject
        for (int c = 0; c < 4; c++) begin
            apb(1'b1, `ADDR_MODE_CTRL, 32'h0000_0000);
            apb(1'b1, `ADDR_PRESCALER, {26'h0, 2'(c), 4'h3});
            apb(1'b1, `ADDR_CAPCMP_A, 32'h0000_0040);
            apb(1'b1, `ADDR_MODE_CTRL, {30'h0, `MODE_CLEAR});
            n = 2 + ($random(seed) & 3);
            u_pulse_source.train(n, 3);
            u_pulse_source.glitch();
            repeat (6) @(posedge pclk);
            rdchk("events", `ADDR_COUNTER, 32'(edges_of(2'(c), n)));
        end
        // Event match at compare value four
        apb(1'b1, `ADDR_MODE_CTRL, 32'h0000_0000);
        apb(1'b1, `ADDR_PRESCALER, 32'h0000_0013);
        apb(1'b1, `ADDR_CAPCMP_A, 32'h0000_0004);
        apb(1'b1, `ADDR_MODE_CTRL, {30'h0, `MODE_CLEAR});
        k = n_match;
        u_pulse_source.train(5, 3);
        repeat (6) @(posedge pclk);
        rdchk("event clear", `ADDR_COUNTER, 32'h0000_0000);
        chk("event match", 32'(n_match - k), 32'h0000_0001);
        // Free-running captures on both inputs
        apb(1'b1, `ADDR_MODE_CTRL, 32'h0000_0000);
        apb(1'b1, `ADDR_CC_CTRL, 32'h0000_0001);
        apb(1'b1, `ADDR_PRESCALER, 32'h0000_0070);
        apb(1'b1, `ADDR_MODE_CTRL, {30'h0, `MODE_FREE});
        k = n_match;
        t0 = cyc;
        u_pulse_source.set(1'b1, 1'b0);
        repeat (10) @(posedge pclk);
        apb(1'b0, `ADDR_CAPCMP_B, 32'h0000_0000);
        c1 = rd[15:0];
        wait_to(t0 + 25);
        u_pulse_source.set(1'b1, 1'b1);
        repeat (10) @(posedge pclk);
        apb(1'b0, `ADDR_CAPCMP_A, 32'h0000_0000);
        c2 = rd[15:0] - c1;
        chk("b capture", {16'h0, c2}, 32'h0000_0019);
        wait_to(t0 + 60);
        u_pulse_source.set(1'b0, 1'b1);
        repeat (10) @(posedge pclk);
        apb(1'b0, `ADDR_CAPCMP_B, 32'h0000_0000);
        c2 = rd[15:0] - c1;
        chk("a width", {16'h0, c2}, 32'h0000_003c);
        chk("capture pulses", 32'(n_capb), 32'h0000_0002);
        chk("match on b", 32'(n_match - k), 32'h0000_0001);
        // Wrap sets the sticky flag; write one clears it
        g = 0;
        while (overflow_flag !== 1'b1 && g < 70000) begin
            @(posedge pclk);
            g++;
        end
        chk("wrap ovf", {31'h0, overflow_flag}, 32'h0000_0001);
        rdchk("status set", `ADDR_STATUS, 32'h0000_0001);
        apb(1'b1, `ADDR_STATUS, 32'h0000_0001);
        rdchk("status clear", `ADDR_STATUS, 32'h0000_0000);
        end_sim();
    end

    // Watchdog beyond the expected run length of about 70000 cycles
    initial begin
        repeat (95000) @(posedge pclk);
        err_total++;
        end_sim();
    end
endmodule // tb_top

bind timer_event_counter_capture timer_monitor u_timer_monitor (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .event_input_a(event_input_a), .event_input_b(event_input_b), .match_a_irq(match_a_irq),
    .capture_b_irq(capture_b_irq), .overflow_flag(overflow_flag),
    .pin_direction_bit(pin_direction_bit), .pin_analog_bit(pin_analog_bit), .pin_out_en(pin_out_en));
`default_nettype wire
